//--- include/rjc_pkg.sv
package rjc_pkg;

  // Parameter word layout
  localparam int RJC_ACT_LSB = 24;
  localparam int RJC_RSN_LSB = 16;
  localparam int RJC_RSV_LSB = 8;
  localparam int RJC_VU_LSB  = 0;

  // Header field and error vector widths
  localparam int RJC_ID_W  = 24;
  localparam int RJC_SID_W = 8;
  localparam int RJC_CNT_W = 16;
  localparam int RJC_ERR_W = 38;

  // Action codes
  localparam logic [7:0] RJC_ACT_RETRY   = 8'h01;
  localparam logic [7:0] RJC_ACT_NORETRY = 8'h02;

  // Reason codes
  localparam logic [7:0] RJC_RSN_NONE      = 8'h00;
  localparam logic [7:0] RJC_RSN_DST_BAD   = 8'h01;
  localparam logic [7:0] RJC_RSN_SRC_BAD   = 8'h02;
  localparam logic [7:0] RJC_RSN_PORT_TMP  = 8'h03;
  localparam logic [7:0] RJC_RSN_PORT_PERM = 8'h04;
  localparam logic [7:0] RJC_RSN_CLASS_NS  = 8'h05;
  localparam logic [7:0] RJC_RSN_UNEXP_ACK = 8'h14;
  localparam logic [7:0] RJC_RSN_LOGIN_REQ = 8'h16;
  localparam logic [7:0] RJC_RSN_VENDOR    = 8'hFF;

  // Reserved byte and default vendor byte
  localparam logic [7:0] RJC_RSV_VAL = 8'h00;
  localparam logic [7:0] RJC_VU_ZERO = 8'h00;

  // Which Reject type may issue a reason
  typedef enum logic [1:0] {
    RJC_BY_NONE,
    RJC_BY_FAB,
    RJC_BY_NXP,
    RJC_BY_BOTH
  } rjc_by_e;

endpackage

//--- include/rjc_link_if.sv
`timescale 1ns/100ps
interface rjc_link_if;
  logic        rjt_valid;
  logic        rjt_ready;
  logic [31:0] rjt_param;
  logic [23:0] rjt_d_id;
  logic [23:0] rjt_s_id;
  logic        rjt_exch_ctx;
  logic        rjt_seq_ctx;
  logic [7:0]  rjt_seq_id;
  logic [15:0] rjt_seq_cnt;
  logic        rjt_eof_term;
  logic        rjt_from_fabric;

  modport gen (
    output rjt_valid, rjt_param, rjt_d_id, rjt_s_id, rjt_exch_ctx, rjt_seq_ctx,
           rjt_seq_id, rjt_seq_cnt, rjt_eof_term, rjt_from_fabric,
    input  rjt_ready
  );

  modport rcv (
    input  rjt_valid, rjt_param, rjt_d_id, rjt_s_id, rjt_exch_ctx, rjt_seq_ctx,
           rjt_seq_id, rjt_seq_cnt, rjt_eof_term, rjt_from_fabric,
    output rjt_ready
  );
endinterface

//--- design/rjc_reject_rcv.sv
`timescale 1ns/100ps
module rjc_reject_rcv (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Link
  rjc_link_if.rcv          link,
  // User side
  output logic             rjt_seen,
  output logic             seq_term_seen,
  output logic             seq_abort_req,
  output logic             rjt_retryable,
  output logic [7:0]       rjt_reason,
  output logic [7:0]       rjt_vendor,
  output logic             rjt_by_fabric
);

  logic       take;
  logic       is_retry;
  logic       seen_r;
  logic       term_r;
  logic       abort_r;
  logic       retry_r;
  logic [7:0] reason_r;
  logic [7:0] vendor_r;
  logic       fab_r;

  assign link.rjt_ready = 1'b1;
  assign take           = link.rjt_valid;
  assign is_retry       = link.rjt_param[rjc_pkg::RJC_ACT_LSB +: 8] == rjc_pkg::RJC_ACT_RETRY;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seen_r   <= 1'b0;
      term_r   <= 1'b0;
      abort_r  <= 1'b0;
      retry_r  <= 1'b0;
      reason_r <= 8'h00;
      vendor_r <= 8'h00;
      fab_r    <= 1'b0;
    end else begin
      seen_r  <= take;
      term_r  <= take && link.rjt_eof_term;
      abort_r <= take && !link.rjt_eof_term;
      if (take) begin
        retry_r  <= is_retry;
        reason_r <= link.rjt_param[rjc_pkg::RJC_RSN_LSB +: 8];
        vendor_r <= link.rjt_param[rjc_pkg::RJC_VU_LSB +: 8];
        fab_r    <= link.rjt_from_fabric;
      end
    end
  end

  assign rjt_seen      = seen_r;
  assign seq_term_seen = term_r;
  assign seq_abort_req = abort_r;
  assign rjt_retryable = retry_r;
  assign rjt_reason    = reason_r;
  assign rjt_vendor    = vendor_r;
  assign rjt_by_fabric = fab_r;

endmodule // rjc_reject_rcv

//--- design/rjc_reject_gen.sv
`timescale 1ns/100ps
module rjc_reject_gen (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  // Port role
  input  wire logic                         port_is_fabric,
  // Received frame
  input  wire logic                         frm_valid,
  output logic                              frm_ready,
  input  wire logic                         frm_ok,
  input  wire logic                         frm_is_rjt,
  input  wire logic                         frm_class2,
  input  wire logic                         frm_class3,
  input  wire logic                         frm_link_ctl,
  input  wire logic                         frm_sof_i2,
  input  wire logic                         frm_xid_assign,
  input  wire logic                         frm_dst_fabric,
  input  wire logic [rjc_pkg::RJC_ID_W-1:0] frm_d_id,
  input  wire logic [rjc_pkg::RJC_ID_W-1:0] frm_s_id,
  input  wire logic                         frm_exch_ctx,
  input  wire logic                         frm_seq_ctx,
  input  wire logic [rjc_pkg::RJC_SID_W-1:0] frm_seq_id,
  input  wire logic [rjc_pkg::RJC_CNT_W-1:0] frm_seq_cnt,
  // Detected errors
  input  wire logic [rjc_pkg::RJC_ERR_W-1:0] err_vec,
  input  wire logic                         vendor_err,
  input  wire logic [7:0]                   vendor_code,
  input  wire logic                         term_req,
  // Outcome
  output logic                              frm_discard,
  output logic                              rjt_sent,
  // Link
  rjc_link_if.gen                           link
);

  typedef enum logic {
    RJC_ST_IDLE,
    RJC_ST_SEND
  } rjc_state_e;

  // Which Reject type may issue a reason; unassigned codes yield none
  function automatic rjc_pkg::rjc_by_e rjc_reason_by(input logic [7:0] code);
    case (code)
      8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h13,
      8'h16, 8'h1C, 8'h1F:                                  rjc_reason_by = rjc_pkg::RJC_BY_BOTH;
      8'h03, 8'h04, 8'h0E, 8'h15, 8'h1A, 8'h25:             rjc_reason_by = rjc_pkg::RJC_BY_FAB;
      8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F,
      8'h10, 8'h11, 8'h12, 8'h14, 8'h17, 8'h18, 8'h24,
      8'hFF:                                                rjc_reason_by = rjc_pkg::RJC_BY_NXP;
      default:                                              rjc_reason_by = rjc_pkg::RJC_BY_NONE;
    endcase
  endfunction

  // Retryable reasons
  function automatic logic rjc_reason_retry(input logic [7:0] code);
    case (code)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h15, 8'h16,
      8'h17, 8'h18, 8'h1A, 8'h24, 8'hFF:                    rjc_reason_retry = 1'b1;
      default:                                              rjc_reason_retry = 1'b0;
    endcase
  endfunction

  // Role and Link_Control filter
  function automatic logic rjc_reason_ok(input logic [7:0] code, input logic fab, input logic lc);
    rjc_pkg::rjc_by_e by;
    logic             role_ok;
    logic             lc_ok;
    by      = rjc_reason_by(code);
    role_ok = (by == rjc_pkg::RJC_BY_BOTH) ||
              (fab && by == rjc_pkg::RJC_BY_FAB) ||
              (!fab && by == rjc_pkg::RJC_BY_NXP);
    if (!lc) begin
      lc_ok = 1'b1;
    end else if (fab) begin
      lc_ok = code == rjc_pkg::RJC_RSN_CLASS_NS  || code == rjc_pkg::RJC_RSN_DST_BAD  ||
              code == rjc_pkg::RJC_RSN_SRC_BAD   || code == rjc_pkg::RJC_RSN_PORT_TMP ||
              code == rjc_pkg::RJC_RSN_PORT_PERM || code == rjc_pkg::RJC_RSN_LOGIN_REQ;
    end else begin
      lc_ok = code == rjc_pkg::RJC_RSN_UNEXP_ACK;
    end
    rjc_reason_ok = role_ok && lc_ok;
  endfunction

  rjc_state_e                    state_r;
  rjc_state_e                    state_nxt;
  logic                          found;
  logic [7:0]                    sel_code;
  logic                          sel_retry;
  logic                          act_ok;
  logic                          frame_ok;
  logic                          accept;
  logic                          do_reject;
  logic                          term_ok;
  logic [7:0]                    sel_action;
  logic [7:0]                    sel_vendor;
  logic [31:0]                   param_r;
  logic [rjc_pkg::RJC_ID_W-1:0]  d_id_r;
  logic [rjc_pkg::RJC_ID_W-1:0]  s_id_r;
  logic                          exch_ctx_r;
  logic                          seq_ctx_r;
  logic [rjc_pkg::RJC_SID_W-1:0] seq_id_r;
  logic [rjc_pkg::RJC_CNT_W-1:0] seq_cnt_r;
  logic                          term_r;
  logic                          fab_r;
  logic                          discard_r;
  logic                          sent_r;

  // First error allowed for role and Link_Control in ascending reason order wins
  always_comb begin
    found    = 1'b0;
    sel_code = rjc_pkg::RJC_RSN_NONE;
    for (int i = 1; i < rjc_pkg::RJC_ERR_W; i++) begin
      if (!found && err_vec[i] && rjc_reason_ok(8'(i), port_is_fabric, frm_link_ctl)) begin
        found    = 1'b1;
        sel_code = 8'(i);
      end
    end
    if (!found && vendor_err && rjc_reason_ok(rjc_pkg::RJC_RSN_VENDOR, port_is_fabric, frm_link_ctl)) begin
      found    = 1'b1;
      sel_code = rjc_pkg::RJC_RSN_VENDOR;
    end
  end

  assign sel_retry  = rjc_reason_retry(sel_code);
  assign sel_action = sel_retry ? rjc_pkg::RJC_ACT_RETRY : rjc_pkg::RJC_ACT_NORETRY;
  assign act_ok     = sel_retry || !port_is_fabric || frm_dst_fabric;
  assign sel_vendor = (sel_code == rjc_pkg::RJC_RSN_VENDOR) ? vendor_code : rjc_pkg::RJC_VU_ZERO;
  assign frame_ok   = frm_ok && !frm_is_rjt && !frm_class3;
  assign frm_ready  = state_r == RJC_ST_IDLE;
  assign accept     = frm_valid && frm_ready;
  assign do_reject  = accept && frame_ok && found && act_ok;
  assign term_ok    = term_req && sel_code != rjc_pkg::RJC_RSN_UNEXP_ACK &&
                      (!frm_class2 || (frm_sof_i2 && frm_xid_assign));

  always_comb begin
    case (state_r)
      RJC_ST_IDLE: state_nxt = do_reject ? RJC_ST_SEND : RJC_ST_IDLE;
      RJC_ST_SEND: state_nxt = link.rjt_ready ? RJC_ST_IDLE : RJC_ST_SEND;
      default:     state_nxt = RJC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r   <= RJC_ST_IDLE;
      discard_r <= 1'b0;
      sent_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      discard_r <= accept && !do_reject;
      sent_r    <= state_r == RJC_ST_SEND && link.rjt_ready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      param_r    <= 32'h0000_0000;
      d_id_r     <= 24'h00_0000;
      s_id_r     <= 24'h00_0000;
      exch_ctx_r <= 1'b0;
      seq_ctx_r  <= 1'b0;
      seq_id_r   <= 8'h00;
      seq_cnt_r  <= 16'h0000;
      term_r     <= 1'b0;
      fab_r      <= 1'b0;
    end else if (do_reject) begin
      param_r    <= {sel_action, sel_code, rjc_pkg::RJC_RSV_VAL, sel_vendor};
      d_id_r     <= frm_s_id;
      s_id_r     <= frm_d_id;
      exch_ctx_r <= !frm_exch_ctx;
      seq_ctx_r  <= !frm_seq_ctx;
      seq_id_r   <= frm_seq_id;
      seq_cnt_r  <= frm_seq_cnt;
      term_r     <= term_ok;
      fab_r      <= port_is_fabric;
    end
  end

  assign link.rjt_valid       = state_r == RJC_ST_SEND;
  assign link.rjt_param       = param_r;
  assign link.rjt_d_id        = d_id_r;
  assign link.rjt_s_id        = s_id_r;
  assign link.rjt_exch_ctx    = exch_ctx_r;
  assign link.rjt_seq_ctx     = seq_ctx_r;
  assign link.rjt_seq_id      = seq_id_r;
  assign link.rjt_seq_cnt     = seq_cnt_r;
  assign link.rjt_eof_term    = term_r;
  assign link.rjt_from_fabric = fab_r;
  assign frm_discard          = discard_r;
  assign rjt_sent             = sent_r;

endmodule // rjc_reject_gen

//--- verification/rjc_link_assertions.sv
`timescale 1ns/100ps
module rjc_link_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Link
  input wire logic        rjt_valid,
  input wire logic        rjt_ready,
  input wire logic [31:0] rjt_param,
  input wire logic        rjt_eof_term,
  input wire logic        rjt_from_fabric
);
  wire logic [7:0] act_w = rjt_param[31:24];
  wire logic [7:0] rsn_w = rjt_param[23:16];
  wire logic       ret_w = rsn_w inside {[8'h01:8'h05], [8'h15:8'h18], 8'h1A, 8'h24, 8'hFF};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  act_code_a: assert property (rjt_valid |-> act_w inside {8'h01, 8'h02})
    else $error("action code out of range");
  retry_map_a: assert property (rjt_valid && ret_w |-> act_w == 8'h01)
    else $error("retryable reason without retry action");
  noretry_map_a: assert property (rjt_valid && !ret_w |-> act_w == 8'h02)
    else $error("non-retryable reason without non-retry action");
  resv_reason_a: assert property (rjt_valid |-> !(rsn_w inside {8'h00, 8'h19, 8'h1B, [8'h1D:8'h1E], [8'h20:8'h23],
    [8'h26:8'hFE]}))
    else $error("reserved reason code sent");
  fab_only_a: assert property (rjt_valid && !rjt_from_fabric |-> !(rsn_w inside {8'h03, 8'h04, 8'h0E, 8'h15, 8'h1A,
    8'h25}))
    else $error("fabric reason from port");
  nx_only_a: assert property (rjt_valid && rjt_from_fabric |-> !(rsn_w inside {[8'h08:8'h0D], [8'h0F:8'h12], 8'h14,
    8'h17, 8'h18, 8'h24, 8'hFF}))
    else $error("port reason from fabric");
  resv_byte_a: assert property (rjt_valid |-> rjt_param[15:8] == 8'h00)
    else $error("reserved byte not zero");
  vendor_byte_a: assert property (rjt_valid && rsn_w != 8'hFF |-> rjt_param[7:0] == 8'h00)
    else $error("vendor byte set without vendor reason");
  ack_eofn_a: assert property (rjt_valid && rsn_w == 8'h14 |-> !rjt_eof_term)
    else $error("unexpected ack reject ends with terminate");
  one_beat_a: assert property (rjt_valid && rjt_ready |=> !rjt_valid)
    else $error("reject repeated after handover");

  vendor_c: cover property (rjt_valid && rsn_w == 8'hFF);
  term_c: cover property (rjt_valid && rjt_eof_term);
  fabric_c: cover property (rjt_valid && rjt_from_fabric && act_w == 8'h02);
endmodule // rjc_link_assertions

//--- verification/test_link_reject_code_logic.sv
`timescale 1ns/100ps
module test_link_reject_code_logic;
  typedef struct {
    logic        rej;
    logic [31:0] prm;
    logic [47:0] hdr;
    logic [25:0] seq;
    logic        trm;
    logic        fab;
  } rjc_exp_s;

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        port_is_fabric = 1'b0, frm_valid = 1'b0, frm_ok = 1'b0, frm_is_rjt = 1'b0, frm_class2 = 1'b0;
  logic        frm_class3 = 1'b0, frm_link_ctl = 1'b0, frm_sof_i2 = 1'b0, frm_xid_assign = 1'b0;
  logic        frm_dst_fabric = 1'b0, frm_exch_ctx = 1'b0, frm_seq_ctx = 1'b0, vendor_err = 1'b0, term_req = 1'b0;
  logic [23:0] frm_d_id = '0, frm_s_id = '0;
  logic [7:0]  frm_seq_id = '0, vendor_code = '0, rjt_reason, rjt_vendor;
  logic [15:0] frm_seq_cnt = '0;
  logic [37:0] err_vec = '0;
  logic        frm_ready, frm_discard, rjt_sent, rjt_seen, seq_term_seen, seq_abort_req, rjt_retryable, rjt_by_fabric;
  int          bad_count = 0, samples_checked = 0;
  logic        sent_x = 1'b0;
  rjc_exp_s    q1[$], q2[$], e1, e2;

  always #10 clk_sys = ~clk_sys;

  rjc_link_if link ();
  rjc_reject_gen rjc_reject_gen_inst (.clk_sys, .sys_rst, .port_is_fabric, .frm_valid, .frm_ready, .frm_ok,
    .frm_is_rjt, .frm_class2, .frm_class3, .frm_link_ctl, .frm_sof_i2, .frm_xid_assign, .frm_dst_fabric, .frm_d_id,
    .frm_s_id, .frm_exch_ctx, .frm_seq_ctx, .frm_seq_id, .frm_seq_cnt, .err_vec, .vendor_err, .vendor_code,
    .term_req, .frm_discard, .rjt_sent, .link);
  rjc_reject_rcv rjc_reject_rcv_inst (.clk_sys, .sys_rst, .link, .rjt_seen, .seq_term_seen, .seq_abort_req,
    .rjt_retryable, .rjt_reason, .rjt_vendor, .rjt_by_fabric);
  rjc_link_assertions rjc_link_assertions_inst (.clk_sys, .sys_rst, .rjt_valid(link.rjt_valid),
    .rjt_ready(link.rjt_ready), .rjt_param(link.rjt_param), .rjt_eof_term(link.rjt_eof_term),
    .rjt_from_fabric(link.rjt_from_fabric));

  function automatic logic ret_f(input logic [7:0] b);
    return b inside {[8'h01:8'h05], [8'h15:8'h18], 8'h1A, 8'h24, 8'hFF};
  endfunction

  // Reason allowed for role and frame kind
  function automatic logic ok_for(input logic f, input logic lc, input logic [7:0] b);
    logic both_c, fab_c, nx_c;
    both_c = b inside {8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h13, 8'h16, 8'h1C, 8'h1F};
    fab_c = b inside {8'h03, 8'h04, 8'h0E, 8'h15, 8'h1A, 8'h25};
    nx_c = b inside {[8'h08:8'h0D], [8'h0F:8'h12], 8'h14, 8'h17, 8'h18, 8'h24};
    if (lc) return f ? b inside {[8'h01:8'h05], 8'h16} : b == 8'h14;
    return f ? both_c || fab_c : both_c || nx_c;
  endfunction

  task automatic chk(input logic [47:0] e, input logic [47:0] a);
    samples_checked++;
    if (a !== e) begin
      bad_count++;
      $display("Error at %0t: expected 0x%h got 0x%h", $time, e, a);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Offer one frame and note its expected outcome
  task automatic go(input logic f, input logic [7:0] n);
    logic [37:0] v;
    logic [31:0] w, hd, hs, sq;
    logic [7:0]  r;
    logic        fnd;
    rjc_exp_s    e;
    @(posedge clk_sys);
    w = $urandom;
    hd = $urandom;
    hs = $urandom;
    sq = $urandom;
    v = '0;
    if (n != 8'h00) v[n] = 1'b1;
    if (n < 8'h25 && w[27]) v[n + 1 + hd[31:24] % (37 - n)] = 1'b1;
    fnd = 1'b0;
    r = 8'h00;
    for (int b = 1; b < 38; b++) if (!fnd && v[b] && ok_for(f, &w[11:10], 8'(b))) begin
      fnd = 1'b1;
      r = 8'(b);
    end
    if (!fnd && w[15] && !f && !(&w[11:10])) begin
      fnd = 1'b1;
      r = 8'hFF;
    end
    e.rej = fnd && (|w[2:0]) && !(&w[5:3]) && !(&w[8:6]) && !(f && !w[14] && !ret_f(r));
    e.prm = {ret_f(r) ? 8'h01 : 8'h02, r, 8'h00, r == 8'hFF ? w[24:17] : 8'h00};
    e.hdr = {hs[23:0], hd[23:0]};
    e.seq = {~w[26:25], sq[23:0]};
    e.trm = w[16] && r != 8'h14 && (!w[9] || (w[12] && w[13]));
    e.fab = f;
    q1.push_back(e);
    port_is_fabric <= f;
    frm_valid <= 1'b1;
    frm_ok <= |w[2:0];
    frm_is_rjt <= &w[5:3];
    frm_class3 <= &w[8:6];
    frm_class2 <= w[9];
    frm_link_ctl <= &w[11:10];
    frm_sof_i2 <= w[12];
    frm_xid_assign <= w[13];
    frm_dst_fabric <= w[14];
    vendor_err <= w[15];
    term_req <= w[16];
    vendor_code <= w[24:17];
    frm_exch_ctx <= w[26];
    frm_seq_ctx <= w[25];
    frm_d_id <= hd[23:0];
    frm_s_id <= hs[23:0];
    frm_seq_id <= sq[23:16];
    frm_seq_cnt <= sq[15:0];
    err_vec <= v;
    @(posedge clk_sys);
    frm_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  always @(negedge clk_sys) begin
    chk(sent_x, rjt_sent);
    if (link.rjt_valid === 1'b1 || frm_discard === 1'b1) begin
      if (q1.size() == 0) chk(48'h0, 48'h1);
      else begin
        e1 = q1.pop_front();
        chk(e1.rej, link.rjt_valid);
        chk(!e1.rej, frm_ready);
        if (link.rjt_valid === 1'b1) begin
          chk(e1.prm, link.rjt_param);
          chk(e1.hdr, {link.rjt_d_id, link.rjt_s_id});
          chk(e1.seq, {link.rjt_exch_ctx, link.rjt_seq_ctx, link.rjt_seq_id, link.rjt_seq_cnt});
          chk(e1.trm, link.rjt_eof_term);
          chk(e1.fab, link.rjt_from_fabric);
          q2.push_back(e1);
        end
      end
    end
    if (rjt_seen === 1'b1) begin
      if (q2.size() == 0) chk(48'h0, 48'h1);
      else begin
        e2 = q2.pop_front();
        chk(e2.prm[23:16], rjt_reason);
        chk(e2.prm[7:0], rjt_vendor);
        chk(e2.prm[24], rjt_retryable);
        chk({e2.trm, !e2.trm}, {seq_term_seen, seq_abort_req});
        chk(e2.fab, rjt_by_fabric);
      end
    end else chk(2'b00, {seq_term_seen, seq_abort_req});
    sent_x = link.rjt_valid === 1'b1 && link.rjt_ready === 1'b1;
  end

  initial begin
    void'($urandom(1));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int k = 0; k < 228; k++) go(k[0], 8'((k >> 1) % 38));
    repeat (8) @(posedge clk_sys);
    chk(48'h0, q1.size());
    chk(48'h0, q2.size());
    conclude();
  end

  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule // test_link_reject_code_logic
